// file: hw/sru_map.svh
`ifndef SRU_MAP_SVH
`define SRU_MAP_SVH

// ****************************************************************
// opcode patterns
// ****************************************************************
// upper byte of the literal return, then a zero bit above the byte select
`define SRU_LITRET_OPC    8'h05
`define SRU_LITRET_OPC_HI 23
`define SRU_LITRET_OPC_LO 16
`define SRU_LITRET_ZERO   15
`define SRU_BYTE_BIT      14
`define SRU_LIT_HI        13
`define SRU_LIT_LO        4
`define SRU_DST_HI        3
`define SRU_DST_LO        0
`define SRU_RETURN_OPC    24'h060000

// ****************************************************************
// stack and program counter layout
// ****************************************************************
`define SRU_POP_STEP      16'h0002
`define SRU_PC_HI_BITS    7
`define SRU_FRAME_BIT     0

// ****************************************************************
// timing, in instruction cycles and clocks
// ****************************************************************
`define SRU_CLK_PER_ICYC  4'h2
`define SRU_OLD_ICYC      3'h3
`define SRU_OLD_ICYC_EXC  3'h2
`define SRU_NEW_ICYC      3'h6
`define SRU_NEW_ICYC_EXC  3'h5

// ****************************************************************
// write enables for the working register
// ****************************************************************
`define SRU_BE_WORD       2'h3
`define SRU_BE_BYTE       2'h1

`endif

// file: hw/sru_pkg.sv
`default_nettype none

package sru_pkg;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    SRU_IDLE,
    SRU_POP1,
    SRU_POP2,
    SRU_HOLD
  } sru_state_e;

  // ****************************************************************
  // whole state of the return unit
  // ****************************************************************
  typedef struct packed {
    sru_state_e  state;
    logic [3:0]  cnt;
    logic [3:0]  last;
    logic        is_lit;
    logic        byte_mode;
    logic [9:0]  lit;
    logic [3:0]  dst;
    logic        newer;
    logic [15:0] sp;
    logic [15:0] word1;
    logic [15:0] word2;
    logic        busy;
    logic        mem_rd_en;
    logic [15:0] mem_addr;
    logic        sp_wr_en;
    logic [15:0] sp_value;
    logic        pc_load_en;
    logic [22:0] pc_value;
    logic        frame_wr_en;
    logic        frame_value;
    logic        wreg_wr_en;
    logic [3:0]  wreg_sel;
    logic [15:0] wreg_data;
    logic [1:0]  wreg_byte_en;
    logic        ir_nop_load;
    logic        done;
    logic [2:0]  icyc_used;
  } sru_state_s;

endpackage : sru_pkg

`default_nettype wire

// file: hw/sru_decode.sv
`include "sru_map.svh"
`default_nettype none

module sru_decode (
  input  wire logic [23:0] instr_word,
  output var  logic        hit_return,
  output var  logic        hit_lit,
  output var  logic        byte_mode,
  output var  logic [9:0]  lit,
  output var  logic [3:0]  dst
);

  // ****************************************************************
  // field split and pattern match
  // ****************************************************************
  always_comb begin
    hit_return = (instr_word == `SRU_RETURN_OPC);
    hit_lit    = (instr_word[`SRU_LITRET_OPC_HI:`SRU_LITRET_OPC_LO] == `SRU_LITRET_OPC)
                 && !instr_word[`SRU_LITRET_ZERO];
    byte_mode  = instr_word[`SRU_BYTE_BIT];
    lit        = instr_word[`SRU_LIT_HI:`SRU_LIT_LO];
    dst        = instr_word[`SRU_DST_HI:`SRU_DST_LO];
  end

endmodule // sru_decode

`default_nettype wire

// file: hw/sru_core.sv
`include "sru_map.svh"
`default_nettype none

module sru_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [23:0] instr_word,
  input  wire logic        newer_core,
  input  wire logic        exc_pending,
  input  wire logic [15:0] stack_ptr_reg,
  input  wire logic [15:0] mem_rd_data,
  output var  logic        busy,
  output var  logic        mem_rd_en,
  output var  logic [15:0] mem_addr,
  output var  logic        sp_wr_en,
  output var  logic [15:0] sp_value,
  output var  logic        pc_load_en,
  output var  logic [22:0] pc_value,
  output var  logic        frame_flag_wr_en,
  output var  logic        stack_frame_active_flag,
  output var  logic        wreg_wr_en,
  output var  logic [3:0]  dest_working_reg,
  output var  logic [15:0] wreg_data,
  output var  logic [1:0]  wreg_byte_en,
  output var  logic        ir_nop_load,
  output var  logic        done,
  output var  logic [2:0]  icyc_used
);
  import sru_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one pop step: pointer moves down before the read
  function automatic logic [15:0] pop_addr(input logic [15:0] sp);
    pop_addr = sp - `SRU_POP_STEP;
  endfunction

  // instruction cycles charged for this return
  function automatic logic [2:0] icyc_cost(input logic newer, input logic exc);
    if (newer) begin
      icyc_cost = exc ? `SRU_NEW_ICYC_EXC : `SRU_NEW_ICYC;
    end else begin
      icyc_cost = exc ? `SRU_OLD_ICYC_EXC : `SRU_OLD_ICYC;
    end
  endfunction

  // ****************************************************************
  // decoder
  // ****************************************************************
  logic       dec_return;
  logic       dec_lit;
  logic       dec_byte;
  logic [9:0] dec_lit_val;
  logic [3:0] dec_dst;

  sru_decode u_decode (
    .instr_word (instr_word),
    .hit_return (dec_return),
    .hit_lit    (dec_lit),
    .byte_mode  (dec_byte),
    .lit        (dec_lit_val),
    .dst        (dec_dst)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  sru_state_s st_ff;
  sru_state_s nxt_st;
  logic [2:0] cost;
  logic       start;
  logic [15:0] word2_now;

  // an older short return commits while the second word is still on the read bus
  assign word2_now = (st_ff.cnt == 4'h2) ? mem_rd_data : st_ff.word2;

  // a new return is only taken in SRU_IDLE, which includes the busy done clock; a request during the pop and hold states is dropped
  assign start = instr_valid && (dec_return || dec_lit) && (st_ff.state == SRU_IDLE);
  assign cost  = icyc_cost(newer_core, exc_pending);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.mem_rd_en   = 1'b0;
    nxt_st.sp_wr_en    = 1'b0;
    nxt_st.pc_load_en  = 1'b0;
    nxt_st.frame_wr_en = 1'b0;
    nxt_st.wreg_wr_en  = 1'b0;
    nxt_st.ir_nop_load = 1'b0;
    nxt_st.done        = 1'b0;
    unique case (st_ff.state)
      SRU_IDLE: begin
        if (start) begin
          nxt_st.state     = SRU_POP1;
          nxt_st.busy      = 1'b1;
          nxt_st.cnt       = 4'h0;
          // total clocks minus one; cost is at least two cycles, so four clocks
          nxt_st.last      = 4'(({1'b0, cost} * `SRU_CLK_PER_ICYC) - 4'h1);
          nxt_st.icyc_used = cost;
          nxt_st.is_lit    = dec_lit;
          nxt_st.byte_mode = dec_byte;
          nxt_st.lit       = dec_lit_val;
          nxt_st.dst       = dec_dst;
          nxt_st.newer     = newer_core;
          // first pop: pointer down by two, then read the new top
          nxt_st.sp        = pop_addr(stack_ptr_reg);
          nxt_st.sp_wr_en  = 1'b1;
          nxt_st.sp_value  = pop_addr(stack_ptr_reg);
          nxt_st.mem_rd_en = 1'b1;
          nxt_st.mem_addr  = pop_addr(stack_ptr_reg);
        end
      end
      SRU_POP1: begin
        // second pop issued; total drop is four
        nxt_st.state     = SRU_POP2;
        nxt_st.cnt       = st_ff.cnt + 4'h1;
        nxt_st.sp        = pop_addr(st_ff.sp);
        nxt_st.sp_wr_en  = 1'b1;
        nxt_st.sp_value  = pop_addr(st_ff.sp);
        nxt_st.mem_rd_en = 1'b1;
        nxt_st.mem_addr  = pop_addr(st_ff.sp);
      end
      SRU_POP2: begin
        // memory answers one clock after the address
        nxt_st.state = SRU_HOLD;
        nxt_st.cnt   = st_ff.cnt + 4'h1;
        nxt_st.word1 = mem_rd_data;
      end
      SRU_HOLD: begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
        if (st_ff.cnt == 4'h2) begin
          nxt_st.word2 = mem_rd_data;
        end
        // commit lands on the last clock of the charged cycles
        if (st_ff.cnt + 4'h1 == st_ff.last) begin
          nxt_st.pc_load_en  = 1'b1;
          nxt_st.ir_nop_load = 1'b1;
          nxt_st.done        = 1'b1;
          nxt_st.pc_value[22:16] = st_ff.word1[`SRU_PC_HI_BITS-1:0];
          if (st_ff.newer) begin
            // low pc bit is forced even; the frame flag rides in bit 0
            nxt_st.pc_value[15:0] = {word2_now[15:1], 1'b0};
            nxt_st.frame_wr_en    = 1'b1;
            nxt_st.frame_value    = word2_now[`SRU_FRAME_BIT];
          end else begin
            nxt_st.pc_value[15:0] = word2_now;
          end
          if (st_ff.is_lit) begin
            nxt_st.wreg_wr_en = 1'b1;
            nxt_st.wreg_sel   = st_ff.dst;
            if (st_ff.byte_mode) begin
              // out-of-range literal bits above the byte are dropped
              nxt_st.wreg_data    = {8'h00, st_ff.lit[7:0]};
              nxt_st.wreg_byte_en = `SRU_BE_BYTE;
            end else begin
              nxt_st.wreg_data    = {6'h00, st_ff.lit};
              nxt_st.wreg_byte_en = `SRU_BE_WORD;
            end
          end
        end
        if (st_ff.cnt + 4'h1 == st_ff.last) begin
          nxt_st.state = SRU_IDLE;
        end
        if (st_ff.cnt == st_ff.last) begin
          nxt_st.busy = 1'b0;
        end
      end
    endcase
    // busy stays up through the commit clock, then drops unless that clock takes a new return
    if (st_ff.state == SRU_IDLE && st_ff.done) begin
      nxt_st.busy = start;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs, straight from the state register
  // ****************************************************************
  assign busy                    = st_ff.busy;
  assign mem_rd_en               = st_ff.mem_rd_en;
  assign mem_addr                = st_ff.mem_addr;
  assign sp_wr_en                = st_ff.sp_wr_en;
  assign sp_value                = st_ff.sp_value;
  assign pc_load_en              = st_ff.pc_load_en;
  assign pc_value                = st_ff.pc_value;
  assign frame_flag_wr_en        = st_ff.frame_wr_en;
  assign stack_frame_active_flag = st_ff.frame_value;
  assign wreg_wr_en              = st_ff.wreg_wr_en;
  assign dest_working_reg        = st_ff.wreg_sel;
  assign wreg_data               = st_ff.wreg_data;
  assign wreg_byte_en            = st_ff.wreg_byte_en;
  assign ir_nop_load             = st_ff.ir_nop_load;
  assign done                    = st_ff.done;
  assign icyc_used               = st_ff.icyc_used;

endmodule // sru_core

`default_nettype wire

// file: bench/sru_props.sv
`default_nettype none

module sru_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic        newer_core,
  input wire logic        exc_pending,
  input wire logic [15:0] stack_ptr_reg,
  input wire logic        busy,
  input wire logic        mem_rd_en,
  input wire logic [15:0] mem_addr,
  input wire logic        sp_wr_en,
  input wire logic [15:0] sp_value,
  input wire logic        pc_load_en,
  input wire logic        frame_flag_wr_en,
  input wire logic        wreg_wr_en,
  input wire logic [3:0]  dest_working_reg,
  input wire logic [1:0]  wreg_byte_en,
  input wire logic        ir_nop_load,
  input wire logic        done
);
  logic        taken;
  logic        new_ff;
  logic [15:0] sp_ff;
  logic [23:0] word_ff;
  // ****************************************************************
  // acceptance tracking
  // ****************************************************************
  // the done clock counts as idle, so a held request is taken there
  assign taken = instr_valid && (!busy || done) &&
    (instr_word == 24'h060000 || (instr_word[23:16] == 8'h05 && !instr_word[15]));
  // operands captured at acceptance, inputs may change afterwards
  always_ff @(posedge clk) begin
    if (taken) begin
      sp_ff   <= stack_ptr_reg;
      word_ff <= instr_word;
      new_ff  <= newer_core;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_pop(logic [15:0] a);
    mem_rd_en && sp_wr_en && mem_addr == a && sp_value == a;
  endsequence
  property p_pops;
    taken |=> s_pop(sp_ff - 16'h0002) ##1 s_pop(sp_ff - 16'h0004);
  endproperty
  a_pops: assert property (p_pops) else $error("stack pops wrong");
  property p_old;
    taken && !newer_core && !exc_pending |=> (busy && !done)[*5] ##1 (busy && done);
  endproperty
  a_old: assert property (p_old) else $error("older cost wrong");
  property p_old_exc;
    taken && !newer_core && exc_pending |=> (busy && !done)[*3] ##1 (busy && done);
  endproperty
  a_old_exc: assert property (p_old_exc) else $error("older short cost wrong");
  property p_new;
    taken && newer_core && !exc_pending |=> !done[*8] ##1 !done[*3] ##1 done;
  endproperty
  a_new: assert property (p_new) else $error("newer cost wrong");
  property p_new_exc;
    taken && newer_core && exc_pending |=> !done[*8] ##1 !done ##1 done;
  endproperty
  a_new_exc: assert property (p_new_exc) else $error("newer short cost wrong");
  property p_commit;
    done |-> pc_load_en && ir_nop_load;
  endproperty
  a_commit: assert property (p_commit) else $error("commit pulses wrong");
  property p_lit;
    done |-> wreg_wr_en == (word_ff[23:16] == 8'h05) && (!wreg_wr_en || dest_working_reg == word_ff[3:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("literal write wrong");
  property p_be;
    done && wreg_wr_en |-> wreg_byte_en == (word_ff[14] ? 2'h1 : 2'h3);
  endproperty
  a_be: assert property (p_be) else $error("byte enables wrong");
  property p_frame;
    done |-> frame_flag_wr_en == new_ff;
  endproperty
  a_frame: assert property (p_frame) else $error("frame flag write wrong");
  property p_refuse;
    instr_valid && !busy && !taken |=> !busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign word taken");
endmodule // sru_props

bind sru_core sru_props props_u (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .newer_core(newer_core), .exc_pending(exc_pending), .stack_ptr_reg(stack_ptr_reg),
  .busy(busy), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .sp_wr_en(sp_wr_en), .sp_value(sp_value),
  .pc_load_en(pc_load_en), .frame_flag_wr_en(frame_flag_wr_en), .wreg_wr_en(wreg_wr_en),
  .dest_working_reg(dest_working_reg),
  .wreg_byte_en(wreg_byte_en), .ir_nop_load(ir_nop_load), .done(done));

`default_nettype wire

// file: bench/sru_core_bench.sv
`default_nettype none

module sru_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] start;
    logic [22:0] pc;
    logic        frame_w, frame_v, wr;
    logic [3:0]  dst;
    logic [15:0] data, mask;
    logic [1:0]  be;
    logic [2:0]  cyc;
  } sru_note_s;
  logic        clk, sys_rst, instr_valid, newer_core, exc_pending, busy, mem_rd_en, sp_wr_en;
  logic        pc_load_en, frame_flag_wr_en, stack_frame_active_flag, wreg_wr_en, ir_nop_load, done;
  logic [23:0] instr_word, w;
  logic [15:0] stack_ptr_reg, mem_rd_data, mem_addr, sp_value, wreg_data, mem_w1, mem_w2, mem_sp;
  logic [22:0] pc_value;
  logic [3:0]  dest_working_reg;
  logic [1:0]  wreg_byte_en;
  logic [2:0]  icyc_used;
  logic [31:0] rnd, cyc;
  int          mismatches, check_count;
  sru_note_s   q[$];
  sru_note_s   e;
  logic [23:0] foreign_words [3] = '{24'h064000, 24'h058000, 24'h060001};

  sru_core dut_u (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .newer_core(newer_core), .exc_pending(exc_pending), .stack_ptr_reg(stack_ptr_reg), .mem_rd_data(mem_rd_data),
    .busy(busy), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .sp_wr_en(sp_wr_en), .sp_value(sp_value),
    .pc_load_en(pc_load_en), .pc_value(pc_value), .frame_flag_wr_en(frame_flag_wr_en),
    .stack_frame_active_flag(stack_frame_active_flag), .wreg_wr_en(wreg_wr_en),
    .dest_working_reg(dest_working_reg), .wreg_data(wreg_data), .wreg_byte_en(wreg_byte_en),
    .ir_nop_load(ir_nop_load), .done(done), .icyc_used(icyc_used));

  // ****************************************************************
  // clock, memory, checking
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one clock read latency; idle bus toggles so stale data never matches
  always @(posedge clk) begin
    if (mem_rd_en === 1'b1) mem_rd_data <= (mem_addr == mem_sp - 16'h2) ? mem_w1 :
      (mem_addr == mem_sp - 16'h4) ? mem_w2 : 16'hbad0;
    else mem_rd_data <= ~mem_rd_data;
  end
  // oldest note against each commit, elapsed clocks included
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1 && q.size() == 0) begin
      check("done", done, 1'b0);
    end else if (done === 1'b1) begin
      e = q.pop_front();
      check("pc_value", pc_value, e.pc);
      check("frame_flag_wr_en", frame_flag_wr_en, e.frame_w);
      if (e.frame_w) check("frame_flag", stack_frame_active_flag, e.frame_v);
      check("wreg_wr_en", wreg_wr_en, e.wr);
      if (e.wr) check("dest", dest_working_reg, e.dst);
      if (e.wr) check("wreg_data", wreg_data & e.mask, e.data & e.mask);
      if (e.wr) check("byte_en", wreg_byte_en, e.be);
      check("ir_nop_load", ir_nop_load, 1'b1);
      check("icyc_used", icyc_used, e.cyc);
      check("clocks", cyc - e.start, {e.cyc, 1'b0});
    end
  end

  // ****************************************************************
  // stimulus
  // ****************************************************************
  task run(input logic [23:0] wd, input logic nw, input logic ex, input logic [31:0] r);
    sru_note_s n;
    mem_w1 = r[15:0];
    mem_w2 = r[31:16];
    mem_sp = {r[25:11], 1'b0};
    n = '0;
    n.pc = {mem_w1[6:0], mem_w2[15:1], nw ? 1'b0 : mem_w2[0]};
    n.frame_w = nw;
    n.frame_v = mem_w2[0];
    n.wr = wd[23:16] == 8'h05;
    n.dst = wd[3:0];
    n.data = {6'h00, wd[13:4]};
    n.mask = wd[14] ? 16'h00ff : 16'hffff;
    n.be = wd[14] ? 2'h1 : 2'h3;
    n.cyc = nw ? (ex ? 3'h5 : 3'h6) : (ex ? 3'h2 : 3'h3);
    @(negedge clk);
    {instr_valid, instr_word, newer_core, exc_pending, stack_ptr_reg} = {1'b1, wd, nw, ex, mem_sp};
    @(posedge clk);
    n.start = cyc;
    q.push_back(n);
    @(negedge clk);
    {instr_valid, newer_core, exc_pending, stack_ptr_reg} = {1'b0, ~nw, ~ex, r[15:0]};
    for (int k = 0; k < 40 && q.size() != 0; k++) @(posedge clk);
  endtask
  initial begin
    {sys_rst, instr_valid, newer_core, exc_pending} = 4'h8;
    {instr_word, stack_ptr_reg, mem_rd_data, mem_w1, mem_w2, mem_sp} = '0;
    {mismatches, check_count, cyc, rnd} = {32'h0, 32'h0, 32'h0, 32'h0f19};
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // every kind crossed with both variants and both exception states
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      case (i[3:2])
        2'h0: w = 24'h060000;
        2'h1: w = {8'h05, 2'b00, rnd[13:0]};
        2'h2: w = {8'h05, 2'b01, 2'b00, rnd[11:0]};
        default: w = {8'h05, 2'b00, 10'h3ff, 4'hf};
      endcase
      run(w, i[0], i[1], rnd);
    end
    // neighbouring encodings must be ignored
    foreach (foreign_words[j]) begin
      @(negedge clk);
      {instr_valid, instr_word} = {1'b1, foreign_words[j]};
      @(negedge clk);
      instr_valid = 1'b0;
      // a taken word would already show busy here, before any run could end
      check("busy", busy, 1'b0);
      repeat (14) @(posedge clk);
    end
    results();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // sru_core_bench

`default_nettype wire
